/* File: fms_defines.svh */
// Register offsets, field positions, reset values and fixed figures of the clock mode selector.
`ifndef FMS_DEFINES_SVH
`define FMS_DEFINES_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define FMS_OFS_CTRL      8'h00
`define FMS_OFS_STATUS    8'h04

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define FMS_CTRL_CSEL_LSB   0
`define FMS_CTRL_REFDIV_LSB 2
`define FMS_CTRL_IREF_BIT   5
`define FMS_CTRL_PHSEL_BIT  6
`define FMS_CTRL_LOWPWR_BIT 7
`define FMS_CTRL_BUSDIV_LSB 8

// ---------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------
`define FMS_STAT_MODE_LSB 0
`define FMS_STAT_SRC_LSB  2
`define FMS_STAT_REXT_BIT 4
`define FMS_STAT_FLL_BIT  5
`define FMS_STAT_PLLP_BIT 6

// ---------------------------------------------------------------
// Reset values and fixed figures
// ---------------------------------------------------------------
`define FMS_RST_CSEL      2'h0
`define FMS_RST_REFDIV    3'h0
`define FMS_RST_IREF      1'h1
`define FMS_RST_PHSEL     1'h0
`define FMS_RST_LOWPWR    1'h0
`define FMS_RST_BUSDIV    2'h1
`define FMS_FLL_MULT      11'h400
`define FMS_SYNC_STAGES   2

`endif

/* File: fms_pkg.sv */
// Types shared by the clock mode selector files.
package fms_pkg;

  typedef enum logic [1:0] {
    LOOP_ENGAGED_INTERNAL,
    LOOP_ENGAGED_EXTERNAL,
    LOOP_BYPASSED_INTERNAL,
    LOOP_BYPASSED_EXTERNAL
  } fms_mode_type;

  typedef enum logic [1:0] {
    SRC_LOOP,
    SRC_INTERNAL,
    SRC_EXTERNAL
  } fms_src_type;

  typedef struct packed {
    logic [1:0] bus_divider;
    logic       low_power_bit;
    logic       phase_loop_select;
    logic       internal_ref_select;
    logic [2:0] ref_divider;
    logic [1:0] clock_source_select;
  } fms_ctrl_type;

  typedef struct packed {
    logic        int_ref;
    logic        ext_ref;
    logic        fll_clk;
  } fms_clk_in_type;

  typedef struct packed {
    fms_ctrl_type  ctrl;
    fms_mode_type  mode;
    fms_src_type   main_src;
    logic          main_clock_out;
    logic          loop_clock_out;
    logic          fll_ref_external;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
  } fms_state_type;

endpackage

/* File: fms_sync.sv */
// Two-stage synchroniser for a group of single-bit levels arriving from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module fms_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             i_clock,
  input  wire logic             i_sys_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
          meta_r[gi] <= 1'b0;
          o_sync[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= i_async[gi];
          o_sync[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* File: fms_top.sv */
// Clock mode selector: APB control registers, mode decode and main and loop clock routing.
//
// Overview of operation
// (R1) Loop-engaged internal mode takes the main clock from the locked loop fed by the internal reference.
// (R2) While the locked loop runs it targets 1024 times the reference divided by the ref divider.
// (R3) In every mode the loop clock output comes from the locked loop and the phase loop is held in low power.
// (R4) Clock source 00 with internal ref select 0 and phase loop select 0 gives loop-engaged external mode.
// (R5) Software sets the ref divider so the divided external reference lies in 31.25 to 39.0625 kHz.
// (R6) Loop-engaged external mode takes the main clock from the locked loop fed by the external reference.
// (R7) Loop-bypassed internal mode drives the main clock from the internal reference, loop still running.
// (R8) Source 01, internal ref 1, phase loop 0, ref divider 000 and low power 0 give bypassed internal mode.
// (R9) Loop-bypassed external mode drives the main clock from the external reference, loop still running.
// (R10) With the bus divider at divide-by-1 software keeps the ref divider below 010 for bypassed external.
// (R11) With the bus divider at divide-by-2 software keeps the ref divider below 011 for bypassed external.
// (R12) After reset the block is in loop-engaged internal mode with the bus divider at divide-by-2.
// (R13) From the reset mode software moves only to engaged external, bypassed external or bypassed internal.
// (R14) Internal ref select 0 with source 10 gives bypassed external mode, routing the external reference.
// (R15) The mode is decoded from the stored fields and held unchanged when no listed combination matches.
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "fms_defines.svh"
module fms_top
  import fms_pkg::*;
(
  input  wire logic        I_CLOCK,
  input  wire logic        I_SYS_RST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  input  wire logic [3:0]  I_PSTRB,
  output var  logic [31:0] O_PRDATA,
  output var  logic        O_PREADY,
  output var  logic        O_PSLVERR,
  input  wire logic        I_INT_REF,
  input  wire logic        I_EXT_REF,
  input  wire logic        I_FLL_CLK,
  output var  logic        O_MAIN_CLOCK_OUT,
  output var  logic        O_LOOP_CLOCK_OUT,
  output var  logic        O_FLL_REF_EXTERNAL,
  output var  logic [2:0]  O_REF_DIVIDER,
  output var  logic [10:0] O_FLL_MULT,
  output var  logic        O_PLL_LOW_POWER,
  output var  logic [1:0]  O_BUS_DIVIDER,
  output var  logic [1:0]  O_MODE
);

  // ---------------------------------------------------------------
  // Reference and loop clock synchronisers
  // ---------------------------------------------------------------
  fms_clk_in_type clk_raw;
  fms_clk_in_type clk_sync;

  assign clk_raw.int_ref = I_INT_REF;
  assign clk_raw.ext_ref = I_EXT_REF;
  assign clk_raw.fll_clk = I_FLL_CLK;

  fms_sync #(
    .WIDTH ($bits(fms_clk_in_type))
  ) u_sync (
    .i_clock   (I_CLOCK),
    .i_sys_rst (I_SYS_RST),
    .i_async   (clk_raw),
    .o_sync    (clk_sync)
  );

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  function automatic fms_mode_type decode_mode(input fms_ctrl_type c, input fms_mode_type cur);
    fms_mode_type m;
    m = cur;
    if (c.phase_loop_select == 1'b0) begin
      if (c.clock_source_select == 2'h0 && c.internal_ref_select) begin
        m = LOOP_ENGAGED_INTERNAL; // R1
      end else if (c.clock_source_select == 2'h0 && !c.internal_ref_select) begin
        m = LOOP_ENGAGED_EXTERNAL; // R4
      end else if (c.clock_source_select == 2'h1 && c.internal_ref_select &&
                   c.ref_divider == 3'h0 && !c.low_power_bit) begin
        m = LOOP_BYPASSED_INTERNAL; // R8
      end else if (c.clock_source_select == 2'h2 && !c.internal_ref_select) begin
        m = LOOP_BYPASSED_EXTERNAL; // R14
      end
    end
    return m; // R15
  endfunction

  function automatic fms_src_type mode_source(input fms_mode_type m);
    fms_src_type s;
    unique case (m)
      LOOP_ENGAGED_INTERNAL:  s = SRC_LOOP;     // R1
      LOOP_ENGAGED_EXTERNAL:  s = SRC_LOOP;     // R6
      LOOP_BYPASSED_INTERNAL: s = SRC_INTERNAL; // R7
      LOOP_BYPASSED_EXTERNAL: s = SRC_EXTERNAL; // R9
    endcase
    return s;
  endfunction

  // ---------------------------------------------------------------
  // State and next-state logic
  // ---------------------------------------------------------------
  fms_state_type state_r;
  fms_state_type state_nxt;

  logic          acc;
  logic          wr_take;
  logic          rd_take;
  logic          addr_ok;
  fms_ctrl_type  wr_ctrl;
  fms_mode_type  mode_dec;
  logic [31:0]   rd_word;

  always_comb begin
    state_nxt = state_r;
    acc       = I_PSEL && I_PENABLE;
    addr_ok   = (I_PADDR == `FMS_OFS_CTRL) || (I_PADDR == `FMS_OFS_STATUS);
    wr_take   = acc && state_r.pready && I_PWRITE && (I_PADDR == `FMS_OFS_CTRL);
    rd_take   = acc && !state_r.pready && !I_PWRITE;

    // Byte lanes 0 and 1 hold the control fields; other lanes are ignored.
    wr_ctrl = state_r.ctrl;
    if (I_PSTRB[0]) begin
      wr_ctrl.clock_source_select = I_PWDATA[`FMS_CTRL_CSEL_LSB +: 2];
      wr_ctrl.ref_divider         = I_PWDATA[`FMS_CTRL_REFDIV_LSB +: 3];
      wr_ctrl.internal_ref_select = I_PWDATA[`FMS_CTRL_IREF_BIT];
      wr_ctrl.phase_loop_select   = I_PWDATA[`FMS_CTRL_PHSEL_BIT];
      wr_ctrl.low_power_bit       = I_PWDATA[`FMS_CTRL_LOWPWR_BIT];
    end
    if (I_PSTRB[1]) begin
      wr_ctrl.bus_divider = I_PWDATA[`FMS_CTRL_BUSDIV_LSB +: 2];
    end
    if (wr_take) begin
      state_nxt.ctrl = wr_ctrl;
    end

    // Mode follows the stored fields one cycle after they change.
    mode_dec           = decode_mode(state_r.ctrl, state_r.mode); // R15
    state_nxt.mode     = mode_dec;
    state_nxt.main_src = mode_source(mode_dec);

    // The loop reference is internal in the internal modes, external otherwise.
    state_nxt.fll_ref_external = (mode_dec == LOOP_ENGAGED_EXTERNAL) ||
                                 (mode_dec == LOOP_BYPASSED_EXTERNAL); // R6

    // Main clock follows the selected source; the loop clock always follows the loop.
    unique case (state_r.main_src)
      SRC_INTERNAL: state_nxt.main_clock_out = clk_sync.int_ref; // R7
      SRC_EXTERNAL: state_nxt.main_clock_out = clk_sync.ext_ref; // R9
      default:      state_nxt.main_clock_out = clk_sync.fll_clk; // R1
    endcase
    state_nxt.loop_clock_out = clk_sync.fll_clk; // R3

    // Status and read data.
    rd_word = 32'h0000_0000;
    if (I_PADDR == `FMS_OFS_CTRL) begin
      rd_word[`FMS_CTRL_CSEL_LSB +: 2]   = state_r.ctrl.clock_source_select;
      rd_word[`FMS_CTRL_REFDIV_LSB +: 3] = state_r.ctrl.ref_divider;
      rd_word[`FMS_CTRL_IREF_BIT]        = state_r.ctrl.internal_ref_select;
      rd_word[`FMS_CTRL_PHSEL_BIT]       = state_r.ctrl.phase_loop_select;
      rd_word[`FMS_CTRL_LOWPWR_BIT]      = state_r.ctrl.low_power_bit;
      rd_word[`FMS_CTRL_BUSDIV_LSB +: 2] = state_r.ctrl.bus_divider;
    end else if (I_PADDR == `FMS_OFS_STATUS) begin
      rd_word[`FMS_STAT_MODE_LSB +: 2] = state_r.mode;
      rd_word[`FMS_STAT_SRC_LSB +: 2]  = state_r.main_src;
      rd_word[`FMS_STAT_REXT_BIT]      = state_r.fll_ref_external;
      rd_word[`FMS_STAT_FLL_BIT]       = 1'b1;
      rd_word[`FMS_STAT_PLLP_BIT]      = 1'b1;
    end

    // One wait state: ready rises after the first access cycle, drops after completion.
    state_nxt.pready  = acc && !state_r.pready;
    state_nxt.pslverr = acc && !state_r.pready && !addr_ok;
    if (rd_take) begin
      state_nxt.prdata = rd_word;
    end else if (!acc) begin
      state_nxt.prdata = 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      state_r.ctrl.clock_source_select <= `FMS_RST_CSEL; // R12
      state_r.ctrl.ref_divider         <= `FMS_RST_REFDIV;
      state_r.ctrl.internal_ref_select <= `FMS_RST_IREF;
      state_r.ctrl.phase_loop_select   <= `FMS_RST_PHSEL;
      state_r.ctrl.low_power_bit       <= `FMS_RST_LOWPWR;
      state_r.ctrl.bus_divider         <= `FMS_RST_BUSDIV; // R12
      state_r.mode                     <= LOOP_ENGAGED_INTERNAL; // R12
      state_r.main_src                 <= SRC_LOOP;
      state_r.main_clock_out           <= 1'b0;
      state_r.loop_clock_out           <= 1'b0;
      state_r.fll_ref_external         <= 1'b0;
      state_r.pready                   <= 1'b0;
      state_r.pslverr                  <= 1'b0;
      state_r.prdata                   <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // The loop lock target and phase loop power state are fixed in every mode.
  logic [10:0] fll_mult_r;
  logic        pll_low_power_r;

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      fll_mult_r      <= `FMS_FLL_MULT; // R2
      pll_low_power_r <= 1'b1;          // R3
    end else begin
      fll_mult_r      <= `FMS_FLL_MULT; // R2
      pll_low_power_r <= 1'b1;          // R3
    end
  end

  assign O_PRDATA           = state_r.prdata;
  assign O_PREADY           = state_r.pready;
  assign O_PSLVERR          = state_r.pslverr;
  assign O_MAIN_CLOCK_OUT   = state_r.main_clock_out;
  assign O_LOOP_CLOCK_OUT   = state_r.loop_clock_out;
  assign O_FLL_REF_EXTERNAL = state_r.fll_ref_external;
  assign O_REF_DIVIDER      = state_r.ctrl.ref_divider; // R2
  assign O_FLL_MULT         = fll_mult_r;
  assign O_PLL_LOW_POWER    = pll_low_power_r;
  assign O_BUS_DIVIDER      = state_r.ctrl.bus_divider;
  assign O_MODE             = state_r.mode;

endmodule
`default_nettype wire

/* File: fms_top_chk.sv */
// Port-level checker for mode decode, clock routing and reset values of the selector.
`timescale 1ns/1ps
`default_nettype none
module fms_top_chk (
  input wire logic        I_CLOCK,
  input wire logic        I_SYS_RST,
  input wire logic        I_PWRITE,
  input wire logic        I_INT_REF,
  input wire logic        I_EXT_REF,
  input wire logic        I_FLL_CLK,
  input wire logic        O_PREADY,
  input wire logic        O_MAIN_CLOCK_OUT,
  input wire logic        O_LOOP_CLOCK_OUT,
  input wire logic        O_FLL_REF_EXTERNAL,
  input wire logic [10:0] O_FLL_MULT,
  input wire logic        O_PLL_LOW_POWER,
  input wire logic [1:0]  O_BUS_DIVIDER,
  input wire logic [1:0]  O_MODE
);
  // ---------------------------------------------------------------
  // Cycles since reset or the last mode change
  // ---------------------------------------------------------------
  logic [2:0] age_r;
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) age_r <= 3'h0;
    else if ($changed(O_MODE)) age_r <= 3'h0;
    else if (age_r != 3'h7) age_r <= age_r + 3'h1;
  end
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  mult_fixed_a: assert property (O_FLL_MULT == 11'h400)
    else $error("loop multiplier is not 1024");
  pll_off_a: assert property (O_PLL_LOW_POWER)
    else $error("phase loop left out of low power");
  loop_clk_a: assert property (age_r >= 3'h4 |-> O_LOOP_CLOCK_OUT == $past(I_FLL_CLK, 3))
    else $error("loop clock not taken from locked loop");
  eng_int_src_a: assert property (age_r >= 3'h4 && $stable(O_MODE) && O_MODE == 2'h0 |->
    O_MAIN_CLOCK_OUT == $past(I_FLL_CLK, 3)) else $error("engaged internal source wrong");
  eng_ext_src_a: assert property (age_r >= 3'h4 && $stable(O_MODE) && O_MODE == 2'h1 |->
    O_MAIN_CLOCK_OUT == $past(I_FLL_CLK, 3)) else $error("engaged external source wrong");
  byp_int_src_a: assert property (age_r >= 3'h4 && $stable(O_MODE) && O_MODE == 2'h2 |->
    O_MAIN_CLOCK_OUT == $past(I_INT_REF, 3)) else $error("bypassed internal source wrong");
  byp_ext_src_a: assert property (age_r >= 3'h4 && $stable(O_MODE) && O_MODE == 2'h3 |->
    O_MAIN_CLOCK_OUT == $past(I_EXT_REF, 3)) else $error("bypassed external source wrong");
  ref_ext_a: assert property (O_FLL_REF_EXTERNAL == O_MODE[0])
    else $error("loop reference choice disagrees with mode");
  // A write completes two edges before the decoded mode can first be seen to change.
  mode_hold_a: assert property ($changed(O_MODE) |->
    $past(O_PREADY, 2) && $past(I_PWRITE, 2)) else $error("mode changed without a register write");
  reset_vals_a: assert property ($fell(I_SYS_RST) |->
    O_BUS_DIVIDER == 2'h1 && O_MODE == 2'h0) else $error("reset mode or bus divider wrong");
  cover property (O_MODE == 2'h1);
  cover property (O_MODE == 2'h2);
  cover property (O_MODE == 2'h3);
endmodule
bind fms_top fms_top_chk u_chk (.I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST), .I_PWRITE(I_PWRITE),
  .I_INT_REF(I_INT_REF), .I_EXT_REF(I_EXT_REF), .I_FLL_CLK(I_FLL_CLK), .O_PREADY(O_PREADY),
  .O_MAIN_CLOCK_OUT(O_MAIN_CLOCK_OUT), .O_LOOP_CLOCK_OUT(O_LOOP_CLOCK_OUT),
  .O_FLL_REF_EXTERNAL(O_FLL_REF_EXTERNAL), .O_FLL_MULT(O_FLL_MULT),
  .O_PLL_LOW_POWER(O_PLL_LOW_POWER), .O_BUS_DIVIDER(O_BUS_DIVIDER), .O_MODE(O_MODE));
`default_nettype wire

/* File: fms_top_bench.sv */
// Self-checking bench for the selector: bus tasks, a table of mode writes and reset checks.
`timescale 1ns/1ps
`default_nettype none
module fms_top_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [3:0]  pstb = 4'h0;
  logic [2:0]  refs = 3'h0;
  logic [2:0]  lag;
  logic [31:0] prd, rd;
  logic        prdy, perr, er, mclk, lclk, rext, pllp;
  logic [2:0]  rdv;
  logic [10:0] mult;
  logic [1:0]  bdv, mode;
  int          cyc = 0;
  int          n_errors = 0;
  int          n_tests = 0;
  logic [9:0]  wv [11] = '{10'h000, 10'h022, 10'h002, 10'h061, 10'h021, 10'h0A1, 10'h025,
                           10'h020, 10'h003, 10'h10C, 10'h106};
  logic [1:0]  wm [11] = '{2'h1, 2'h1, 2'h3, 2'h3, 2'h2, 2'h2, 2'h2, 2'h0, 2'h0, 2'h1, 2'h3};
  fms_top u_dut (.I_CLOCK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(padr), .I_PWDATA(pwd), .I_PSTRB(pstb), .O_PRDATA(prd),
    .O_PREADY(prdy), .O_PSLVERR(perr), .I_INT_REF(refs[1]), .I_EXT_REF(refs[2]),
    .I_FLL_CLK(refs[0]), .O_MAIN_CLOCK_OUT(mclk), .O_LOOP_CLOCK_OUT(lclk),
    .O_FLL_REF_EXTERNAL(rext), .O_REF_DIVIDER(rdv), .O_FLL_MULT(mult),
    .O_PLL_LOW_POWER(pllp), .O_BUS_DIVIDER(bdv), .O_MODE(mode));
  // Reference levels as they were three edges ago: two sync stages plus the output register.
  assign lag = refs - 3'h3;
  // ---------------------------------------------------------------
  // Clock, reference levels at three rates and the timeout
  // ---------------------------------------------------------------
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    refs <= refs + 3'h1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    pstb <= s;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Status word expected for a mode: loop running, phase loop parked, source and mode.
  function automatic logic [31:0] stat(input logic [1:0] m);
    return {25'h0, 2'h3, m[0], (m == 2'h2) ? 2'h1 : (m == 2'h3) ? 2'h2 : 2'h0, m};
  endfunction
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk(rd, 32'h120);
    chk(32'(bdv), 32'h1);
    apb(1'b0, 8'h04, 32'h0, 4'h0);
    chk(rd, stat(2'h0));
    for (int i = 0; i < 11; i++) begin
      apb(1'b1, 8'h00, 32'(wv[i]), 4'h3);
      repeat (6) @(posedge clk);
      chk(32'(lclk), 32'(lag[0]));
      chk(32'(mclk), 32'(lag[wm[i][1] ? 2'(wm[i] - 2'h1) : 2'h0]));
      chk(32'(mult), 32'h400);
      chk(32'(pllp), 32'h1);
      chk(32'(mode), 32'(wm[i]));
      chk(32'(rext), 32'(wm[i][0]));
      chk(32'(rdv), 32'(wv[i][4:2]));
      chk(32'(bdv), 32'(wv[i][9:8]));
      apb(1'b0, 8'h04, 32'h0, 4'h0);
      chk(rd, stat(wm[i]));
      apb(1'b0, 8'h00, 32'h0, 4'h0);
      chk(rd, 32'(wv[i]));
    end
    apb(1'b1, 8'h04, 32'h0, 4'hF);
    apb(1'b1, 8'h00, 32'h300, 4'h1);
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk(rd, 32'h100);
    apb(1'b1, 8'h08, 32'h2, 4'h3);
    chk(32'(er), 32'h1);
    apb(1'b0, 8'h08, 32'h0, 4'h0);
    chk(rd, 32'h0);
    chk(32'(er), 32'h1);
    chk(32'(mode), 32'h1);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk(rd, 32'h120);
    chk(32'(mode), 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
